/* File: upr_pkg.sv */
// constants for the usb port signal routing block
// assumes a 25 MHz system clock and a synchronous active-low reset
// Operation
// - positive line to usb, right audio, or uart
// - negative line to usb, left audio, or uart
// - watch ident pin for accessories and buttons
// - charger flag open-drain, low means attached
// - irq push-pull low on ident or attach change
// - two factory-test outputs: open-drain and push-pull
// - every reset opens all switch paths
// - fast-mode i2c slave, up to 400 kHz
// - both i2c lines low 30 ms resets
package upr_pkg;
  localparam int CLK_HZ = 25000000;
  localparam int BUS_LOW_RESET_MS = 30;
  localparam int BUS_LOW_RESET_CYC = (CLK_HZ / 1000) * BUS_LOW_RESET_MS;
  localparam int I2C_MAX_KHZ = 400;
  localparam int CNT_W = 20;
  localparam int PATH_W = 3;
  // one-hot path selects per connector line
  localparam logic [2:0] PATH_OPEN = 3'h0;
  localparam logic [2:0] PATH_USB = 3'h1;
  localparam logic [2:0] PATH_AUDIO = 3'h2;
  localparam logic [2:0] PATH_UART = 3'h4;
  // signalling modes requested by the detection logic
  typedef enum logic [3:0] {
    UPR_MODE_OPEN = 4'h1,
    UPR_MODE_USB = 4'h2,
    UPR_MODE_AUDIO = 4'h4,
    UPR_MODE_UART = 4'h8
  } upr_mode_t;
endpackage : upr_pkg

/* File: upr_signal_routing.sv */
// switch-path control, ident watch, charger/factory/irq pins and bus-stuck reset
// assumes detection and the i2c slave sit beside it on the same clock
`timescale 1ns/1ps
module upr_signal_routing #(
  parameter int BUS_LOW_RESET_CYC = upr_pkg::BUS_LOW_RESET_CYC
) (
  input wire logic clock, // 25 MHz system clock
  input wire logic nrst, // synchronous reset, active low
  input wire logic [3:0] modeReq, // one-hot signalling mode request
  input wire logic chargerSeen, // detection found a charger
  input wire logic accessoryAttached, // detection attach status
  input wire logic factoryTestReq, // request open-drain factory flag low
  input wire logic factoryBootReq, // request push-pull factory output high
  input wire logic connectorIdentPin, // asynchronous ident pin level
  input wire logic sclIn, // i2c clock pin level
  input wire logic sdaIn, // i2c data pin level
  input wire logic vddioValid, // i/o supply good
  input wire logic statusRead, // i2c slave read the status bits
  output logic [2:0] posPathSel_q, // positive line: usb, right, rx
  output logic [2:0] negPathSel_q, // negative line: usb, left, tx
  output logic identLevel_q, // synchronised ident level
  output logic identChanged_q, // sticky ident change seen
  output logic attachChanged_q, // sticky attach change seen
  output logic chargerAttachedNOe_q, // low drives charger_attached_n low
  output logic factoryTestFlagOe_q, // low drives factory flag low
  output logic factoryBoot_q, // push-pull factory output
  output logic irq_n_q, // interrupt, active low
  output logic busResetReq_q // pulse: bus-stuck reset fired
);
  logic identMeta_q;
  logic identSync_q;
  logic sclMeta_q, sclSync_q, sdaMeta_q, sdaSync_q, vddMeta_q, vddSync_q;
  logic attachPrev_q;
  logic busStuckPrev_q;
  logic [upr_pkg::CNT_W-1:0] lowCnt_q;
  logic [upr_pkg::CNT_W-1:0] lowCnt_d;
  logic busLow;
  logic busStuck;
  logic rstAll;
  logic identEdge;
  logic attachEdge;
  logic [2:0] pathSel;
  upr_pkg::upr_mode_t mode;

  // both lines low with good supply counts toward a self reset
  assign busLow = ~sclSync_q & ~sdaSync_q & vddSync_q;
  assign busStuck = busLow && (lowCnt_q == upr_pkg::CNT_W'(BUS_LOW_RESET_CYC - 1));
  assign lowCnt_d = busLow ? (busStuck ? lowCnt_q : lowCnt_q + 1'b1) : '0;
  assign rstAll = ~nrst | busStuck;

  // only a legal one-hot mode closes a path, so two paths never short
  assign mode = upr_pkg::upr_mode_t'(modeReq);
  always_comb begin
    unique case (mode)
      upr_pkg::UPR_MODE_USB: pathSel = upr_pkg::PATH_USB;
      upr_pkg::UPR_MODE_AUDIO: pathSel = upr_pkg::PATH_AUDIO;
      upr_pkg::UPR_MODE_UART: pathSel = upr_pkg::PATH_UART;
      upr_pkg::UPR_MODE_OPEN: pathSel = upr_pkg::PATH_OPEN;
      default: pathSel = upr_pkg::PATH_OPEN; // illegal codes stay open
    endcase
  end

  // ident edge and attach edge raise the interrupt
  assign identEdge = identSync_q ^ identLevel_q;
  assign attachEdge = accessoryAttached ^ attachPrev_q;

  // pin synchronisers; first stage feeds only the second
  always_ff @(posedge clock) begin
    identMeta_q <= connectorIdentPin;
    identSync_q <= identMeta_q;
    sclMeta_q <= sclIn; // bus pins only watched here, slave sits beside
    sclSync_q <= sclMeta_q;
    sdaMeta_q <= sdaIn;
    sdaSync_q <= sdaMeta_q;
    vddMeta_q <= vddioValid;
    vddSync_q <= vddMeta_q;
  end

  // stuck counter runs through its own reset so a long hold fires once
  // the pulse marks the rising edge of the stuck state, not each cycle of it
  always_ff @(posedge clock) begin
    if (!nrst) begin
      lowCnt_q <= '0;
      busStuckPrev_q <= 1'b0;
      busResetReq_q <= 1'b0;
    end else begin
      lowCnt_q <= lowCnt_d;
      busStuckPrev_q <= busStuck;
      busResetReq_q <= busStuck & ~busStuckPrev_q;
    end
  end

  // path selects, default open after any reset
  always_ff @(posedge clock) begin
    if (rstAll) begin
      posPathSel_q <= upr_pkg::PATH_OPEN;
      negPathSel_q <= upr_pkg::PATH_OPEN;
    end else begin
      posPathSel_q <= pathSel;
      negPathSel_q <= pathSel;
    end
  end

  // sticky change flags; a new edge wins over the read-clear
  always_ff @(posedge clock) begin
    if (rstAll) begin
      identLevel_q <= 1'b0;
      attachPrev_q <= 1'b0;
      identChanged_q <= 1'b0;
      attachChanged_q <= 1'b0;
      irq_n_q <= 1'b1;
    end else begin
      identLevel_q <= identSync_q;
      attachPrev_q <= accessoryAttached;
      identChanged_q <= identEdge | (identChanged_q & ~statusRead);
      attachChanged_q <= attachEdge | (attachChanged_q & ~statusRead);
      irq_n_q <= ~(identEdge | attachEdge | ((identChanged_q | attachChanged_q) & ~statusRead));
    end
  end

  // open-drain enables low to drive; released (high) by default
  always_ff @(posedge clock) begin
    if (rstAll) begin
      chargerAttachedNOe_q <= 1'b1;
      factoryTestFlagOe_q <= 1'b1;
      factoryBoot_q <= 1'b0;
    end else begin
      chargerAttachedNOe_q <= ~chargerSeen;
      factoryTestFlagOe_q <= ~factoryTestReq;
      factoryBoot_q <= factoryBootReq;
    end
  end
endmodule : upr_signal_routing

/* File: upr_asserts.sv */
// port assertions for the routing block
// assumes a bind from the bench top file
`timescale 1ns/1ps
module upr_asserts (
  input wire logic clock, nrst, chargerSeen, accessoryAttached, // control in
  input wire logic factoryTestReq, factoryBootReq, connectorIdentPin, // pins in
  input wire logic [3:0] modeReq, // mode request
  input wire logic [2:0] posPathSel_q, negPathSel_q, // switch paths
  input wire logic identChanged_q, attachChanged_q, irq_n_q, busResetReq_q, // status
  input wire logic chargerAttachedNOe_q, factoryTestFlagOe_q, factoryBoot_q // pins out
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // path selection one cycle after the mode request
  usb_path_a: assert property (modeReq == 4'h2 |=> posPathSel_q == 3'h1) else $error("usb");
  uart_path_a: assert property (modeReq == 4'h8 |=> negPathSel_q == 3'h4) else $error("uart");
  one_path_a: assert property ($onehot0(posPathSel_q) && negPathSel_q == posPathSel_q)
    else $error("paths");
  // sync plus edge detect takes a few cycles
  ident_irq_a: assert property ($changed(connectorIdentPin) |-> ##[1:5] !irq_n_q)
    else $error("ident");
  irq_flag_a: assert property (irq_n_q == !(identChanged_q || attachChanged_q)) else $error("irq");
  attach_irq_a: assert property ($changed(accessoryAttached) |=> attachChanged_q && !irq_n_q)
    else $error("attach");
  charger_pin_a: assert property (1'b1 |=> chargerAttachedNOe_q == !$past(chargerSeen))
    else $error("charger");
  factory_pins_a: assert property (1'b1 |=> factoryTestFlagOe_q == !$past(factoryTestReq)
    && factoryBoot_q == $past(factoryBootReq)) else $error("factory");
  reset_open_a: assert property ($rose(nrst) |-> posPathSel_q == 3'h0 && irq_n_q
    && chargerAttachedNOe_q && factoryTestFlagOe_q && !factoryBoot_q) else $error("reset");
  bus_reset_a: assert property (busResetReq_q |=> !busResetReq_q && posPathSel_q == 3'h0)
    else $error("bus");
  bus_once_a: assert property (busResetReq_q |=> !busResetReq_q [*8])
    else $error("bus pulse repeated");
  cover property (posPathSel_q == 3'h4);
  cover property (!irq_n_q);
  cover property (busResetReq_q);
endmodule : upr_asserts

/* File: upr_far_side.sv */
// far side: connector ident and processor bus lines
// assumes the bench steers it by level requests
`timescale 1ns/1ps
module upr_far_side (
  input wire logic identReq, busHoldLow, // steering from the bench
  output logic identPin, scl, sda, vddio // pins seen by the block
);
  // bus lines rest high on pull-ups; both pulled low only when asked
  assign identPin = identReq;
  assign scl = !busHoldLow;
  assign sda = !busHoldLow;
  assign vddio = 1'b1;
endmodule : upr_far_side

/* File: upr_signal_routing_tb.sv */
// self-checking bench for the routing block
// assumes the package, far side and checker compile first
`timescale 1ns/1ps
module upr_signal_routing_tb;
  logic clock = 0, nrst = 0, chargerSeen = 0, accessoryAttached = 0, statusRead = 0;
  logic factoryTestReq = 0, factoryBootReq = 0, identReq = 0, busHoldLow = 0;
  logic [3:0] modeReq = 4'h1;
  logic connectorIdentPin, sclIn, sdaIn, vddioValid, irq_n_q, busResetReq_q, identLevel_q;
  logic [2:0] posPathSel_q, negPathSel_q;
  logic identChanged_q, attachChanged_q, chargerAttachedNOe_q, factoryTestFlagOe_q, factoryBoot_q;
  int nMismatch = 0, checkCount = 0;
  upr_signal_routing #(.BUS_LOW_RESET_CYC(20)) dut (.*);
  upr_far_side far (.identReq, .busHoldLow, .identPin(connectorIdentPin), .scl(sclIn),
    .sda(sdaIn), .vddio(vddioValid));
  initial forever #20 clock = !clock;
  task automatic chk(input logic [2:0] got, exp);
    checkCount++;
    if (got !== exp) begin
      nMismatch++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  // every mode, an illegal one among them
  task automatic modeTest;
    logic [3:0] m [5] = '{4'h2, 4'h4, 4'h8, 4'h3, 4'h1};
    logic [2:0] e [5] = '{3'h1, 3'h2, 3'h4, 3'h0, 3'h0};
    for (int i = 0; i < 5; i++) begin
      @(posedge clock) modeReq <= m[i];
      tick(1);
      chk(posPathSel_q, e[i]);
      chk(negPathSel_q, e[i]);
    end
  endtask : modeTest
  task automatic pinTest;
    @(posedge clock) {chargerSeen, factoryTestReq, factoryBootReq} <= 3'h7;
    tick(1);
    chk({chargerAttachedNOe_q, factoryTestFlagOe_q, factoryBoot_q}, 3'h1);
    @(posedge clock) {chargerSeen, factoryTestReq, factoryBootReq} <= 3'h0;
    tick(1);
    chk({chargerAttachedNOe_q, factoryTestFlagOe_q, factoryBoot_q}, 3'h6);
  endtask : pinTest
  task automatic irqTest;
    @(posedge clock) accessoryAttached <= 1;
    tick(1);
    chk({attachChanged_q, irq_n_q, identChanged_q}, 3'h4);
    @(posedge clock) statusRead <= 1;
    @(posedge clock) statusRead <= 0;
    tick(0);
    chk({attachChanged_q, irq_n_q, identChanged_q}, 3'h2);
    @(posedge clock) identReq <= 1;
    tick(6);
    chk({identLevel_q, irq_n_q, identChanged_q}, 3'h5);
  endtask : irqTest
  // audio mode held so the forced open shows at the paths
  task automatic busTest;
    int n = 0;
    @(posedge clock) modeReq <= 4'h4;
    busHoldLow <= 1;
    while (busResetReq_q !== 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    chk({2'h0, n >= 20 && n <= 26}, 3'h1);
    tick(1);
    chk(posPathSel_q | negPathSel_q, 3'h0);
    tick(1);
    chk({2'h0, busResetReq_q}, 3'h0);
    @(posedge clock) busHoldLow <= 0;
  endtask : busTest
  task automatic endOfTest;
    $display("checks %0d mismatches %0d", checkCount, nMismatch);
    if (nMismatch == 0 && checkCount > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : endOfTest
  initial begin
    repeat (12) @(posedge clock);
    nrst <= 1;
    tick(1);
    chk(posPathSel_q | negPathSel_q, 3'h0);
    modeTest();
    pinTest();
    irqTest();
    busTest();
    endOfTest();
  end
  // the tests need about 65 cycles
  initial begin
    repeat (400) @(posedge clock);
    nMismatch++;
    endOfTest();
  end
endmodule : upr_signal_routing_tb
bind upr_signal_routing upr_asserts sva (.*);
